// *** ocpw_consts.svh ***
// Register offsets, field positions and reset values of the compare unit.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef OCPW_CONSTS_SVH
`define OCPW_CONSTS_SVH

`define OCPW_ADDR_W         8
`define OCPW_OFF_CONTROL    8'h00
`define OCPW_OFF_PRIMARY    8'h04
`define OCPW_OFF_SECONDARY  8'h08
`define OCPW_OFF_IRQ_STATUS 8'h0C
`define OCPW_OFF_IRQ_MASK   8'h10

`define OCPW_BIT_ENABLE     15
`define OCPW_BIT_IDLE_STOP  13
`define OCPW_BIT_WIDE       5
`define OCPW_BIT_FAULT      4
`define OCPW_BIT_TIMEBASE   3
`define OCPW_CTRL_WMASK     32'h0000A02F

`define OCPW_IRQ_W          2
`define OCPW_IRQ_COMPARE    0
`define OCPW_IRQ_FAULT      1

`define OCPW_RESET_WORD     32'h00000000

`endif

// *** ocpw_pkg.sv ***
// Types shared by the compare unit modules.
// Assumes nothing of its surroundings.
package ocpw_pkg;

    typedef enum logic [2:0] {
        OCPW_MODE_OFF      = 3'h0,
        OCPW_MODE_SET_HIGH = 3'h1,
        OCPW_MODE_SET_LOW  = 3'h2,
        OCPW_MODE_TOGGLE   = 3'h3,
        OCPW_MODE_SINGLE   = 3'h4,
        OCPW_MODE_CONT     = 3'h5,
        OCPW_MODE_PWM      = 3'h6,
        OCPW_MODE_PWM_FLT  = 3'h7
    } ocpw_mode_type;

endpackage

// *** ocpw_match_if.sv ***
// Carries compare settings and match results between top and comparator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface ocpw_match_if;
    logic [31:0] count;
    logic [31:0] primary;
    logic [31:0] secondary;
    logic        wide;
    logic        hit_primary;
    logic        hit_secondary;

    modport top  (output count, output primary, output secondary, output wide,
                  input hit_primary, input hit_secondary);
    modport comp (input count, input primary, input secondary, input wide,
                  output hit_primary, output hit_secondary);
endinterface

// *** ocpw_comparator.sv ***
// Equality comparator of timer count against both compare values.
// Assumes a count that is stable for the clock cycle.
`timescale 1ns/10ps

module ocpw_comparator (
    ocpw_match_if.comp m
);
    logic [31:0] width_mask;

    // Narrow mode compares the low half only
    assign width_mask      = m.wide ? 32'hFFFFFFFF : 32'h0000FFFF;
    assign m.hit_primary   = ((m.count ^ m.primary) & width_mask) == 32'h00000000;
    assign m.hit_secondary = ((m.count ^ m.secondary) & width_mask) == 32'h00000000;
endmodule

// *** ocpw_top.sv ***
// Output compare and PWM unit with APB register access.
// Assumes timers on pclk; fault and idle inputs come from outside the clock domain.
//
// Overview of operation
// - Enable bit 15 gates the whole unit
// - Idle-stop bit 13 halts unit in idle
// - Wide bit 5 selects 32-bit compare
// - Fault flag bit 4 set and cleared by hardware
// - Timebase bit 3 picks second timer
// - Mode 111 is PWM with fault input
// - Mode 110 is PWM ignoring fault
// - Mode 101 starts low, continuous pulses
// - Mode 100 starts low, one pulse
// - Mode 011 toggles pin on compare
// - Mode 010 starts high, compare forces low
// - Mode 001 starts low, compare forces high
// - Mode 000 disables compare, pin idle
// - Unimplemented control bits read as zero
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps

`include "ocpw_consts.svh"

module ocpw_top
    import ocpw_pkg::*;
#(
    parameter int TIMER_W = 32
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [TIMER_W-1:0] first_timebase,
    input  wire logic [TIMER_W-1:0] second_timebase,
    input  wire logic               idle_mode,
    input  wire logic               fault_n,
    output logic                    compare_output_pin,
    output logic                    irq
);

    // ************************************************************
    // Registers and synchronisers
    // ************************************************************
    logic                   enable_reg;
    logic                   idle_stop_reg;
    logic                   wide_compare_select_reg;
    logic                   timebase_select_reg;
    ocpw_mode_type          compare_mode_select_reg;
    logic                   pwm_fault_flag_reg;
    logic [31:0]            primary_compare_value_reg;
    logic [31:0]            secondary_compare_value_reg;
    logic [`OCPW_IRQ_W-1:0] irq_status_reg;
    logic [`OCPW_IRQ_W-1:0] irq_mask_reg;
    logic                   pin_reg;
    logic                   armed_reg;
    logic                   fault_latched_reg;
    logic [1:0]             idle_sync_reg;
    logic [1:0]             fault_sync_reg;

    logic                   wr_en;
    logic                   rd_en;
    logic                   ctrl_wr;
    logic                   mode_wr;
    logic                   addr_ok;
    logic                   running;
    logic                   fault_now;
    logic                   hit_p;
    logic                   hit_s;
    logic [31:0]            ctrl_word;
    logic [31:0]            rdata_next;
    logic [`OCPW_IRQ_W-1:0] irq_event;

    ocpw_match_if m ();

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_sync_reg  <= 2'h0;
            fault_sync_reg <= 2'h0;
        end else begin
            idle_sync_reg  <= {idle_sync_reg[0], idle_mode};
            fault_sync_reg <= {fault_sync_reg[0], ~fault_n};
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    assign addr_ok = (paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_CONTROL)
                   || (paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_PRIMARY)
                   || (paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_SECONDARY)
                   || (paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_IRQ_STATUS)
                   || (paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_IRQ_MASK);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && penable && !pwrite && addr_ok;
    assign ctrl_wr = wr_en && (paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_CONTROL);
    assign mode_wr = ctrl_wr && (pwdata[2:0] != compare_mode_select_reg);

    // Unimplemented bits stay zero
    assign ctrl_word = {16'h0000, enable_reg, 1'b0, idle_stop_reg, 7'h00,
                        wide_compare_select_reg, pwm_fault_flag_reg,
                        timebase_select_reg, compare_mode_select_reg};

    always_comb begin
        rdata_next = 32'h00000000;
        case (paddr[`OCPW_ADDR_W-1:0])
            `OCPW_OFF_CONTROL:    rdata_next = ctrl_word;
            `OCPW_OFF_PRIMARY:    rdata_next = primary_compare_value_reg;
            `OCPW_OFF_SECONDARY:  rdata_next = secondary_compare_value_reg;
            `OCPW_OFF_IRQ_STATUS: rdata_next = {30'h00000000, irq_status_reg};
            `OCPW_OFF_IRQ_MASK:   rdata_next = {30'h00000000, irq_mask_reg};
            default:              rdata_next = 32'h00000000;
        endcase
    end

    // Zero-wait answer in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= (psel && !penable) ? rdata_next : 32'h00000000;
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg              <= 1'b0;
            idle_stop_reg           <= 1'b0;
            wide_compare_select_reg <= 1'b0;
            timebase_select_reg     <= 1'b0;
            compare_mode_select_reg <= OCPW_MODE_OFF;
        end else if (ctrl_wr) begin
            enable_reg              <= pwdata[`OCPW_BIT_ENABLE];
            idle_stop_reg           <= pwdata[`OCPW_BIT_IDLE_STOP];
            wide_compare_select_reg <= pwdata[`OCPW_BIT_WIDE];
            timebase_select_reg     <= pwdata[`OCPW_BIT_TIMEBASE];
            compare_mode_select_reg <= ocpw_mode_type'(pwdata[2:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_compare_value_reg   <= 32'h00000000;
            secondary_compare_value_reg <= 32'h00000000;
        end else if (wr_en) begin
            if (paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_PRIMARY) begin
                primary_compare_value_reg <= pwdata;
            end
            if (paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_SECONDARY) begin
                secondary_compare_value_reg <= pwdata;
            end
        end
    end

    // ************************************************************
    // Compare datapath
    // ************************************************************
    assign running = enable_reg && !(idle_stop_reg && idle_sync_reg[1]);

    generate
        if (TIMER_W >= 32) begin : g_full
            assign m.count = timebase_select_reg ? second_timebase[31:0]
                                                 : first_timebase[31:0];
        end else begin : g_pad
            assign m.count = {{(32-TIMER_W){1'b0}},
                              timebase_select_reg ? second_timebase
                                                  : first_timebase};
        end
    endgenerate
    assign m.primary   = primary_compare_value_reg;
    assign m.secondary = secondary_compare_value_reg;
    assign m.wide      = wide_compare_select_reg;
    assign hit_p       = running && m.hit_primary;
    assign hit_s       = running && m.hit_secondary;

    ocpw_comparator u_comparator (
        .m (m)
    );

    assign fault_now = running && (compare_mode_select_reg == OCPW_MODE_PWM_FLT)
                     && fault_sync_reg[1];

    // ************************************************************
    // Output pin sequencer
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_reg   <= 1'b0;
            armed_reg <= 1'b0;
        end else if (mode_wr || !enable_reg) begin
            // Initial level on entry to a mode
            pin_reg   <= (ctrl_wr && pwdata[`OCPW_BIT_ENABLE] && pwdata[2:0] == 3'h2);
            armed_reg <= 1'b1;
        end else if (running) begin
            case (compare_mode_select_reg)
                OCPW_MODE_OFF: pin_reg <= 1'b0;
                OCPW_MODE_SET_HIGH: begin
                    if (hit_p) pin_reg <= 1'b1;
                end
                OCPW_MODE_SET_LOW: begin
                    if (hit_p) pin_reg <= 1'b0;
                end
                OCPW_MODE_TOGGLE: begin
                    if (hit_p) pin_reg <= ~pin_reg;
                end
                OCPW_MODE_SINGLE: begin
                    if (hit_p && armed_reg) begin
                        pin_reg <= 1'b1;
                    end else if (hit_s && pin_reg) begin
                        pin_reg   <= 1'b0;
                        armed_reg <= 1'b0;
                    end
                end
                OCPW_MODE_CONT: begin
                    if (hit_p) pin_reg <= 1'b1;
                    else if (hit_s) pin_reg <= 1'b0;
                end
                OCPW_MODE_PWM: begin
                    if (hit_p) pin_reg <= 1'b1;
                    else if (hit_s) pin_reg <= 1'b0;
                end
                OCPW_MODE_PWM_FLT: begin
                    if (fault_now || fault_latched_reg) pin_reg <= 1'b0;
                    else if (hit_p) pin_reg <= 1'b1;
                    else if (hit_s) pin_reg <= 1'b0;
                end
                default: pin_reg <= 1'b0;
            endcase
        end
    end

    // ************************************************************
    // Fault flag
    // ************************************************************
    // Set wins; only a mode change or disable clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_latched_reg <= 1'b0;
        end else if (fault_now) begin
            fault_latched_reg <= 1'b1;
        end else if (mode_wr || !enable_reg) begin
            fault_latched_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_fault_flag_reg <= 1'b0;
        end else begin
            pwm_fault_flag_reg <= fault_latched_reg
                && (compare_mode_select_reg == OCPW_MODE_PWM_FLT);
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign irq_event[`OCPW_IRQ_COMPARE] = hit_p && compare_mode_select_reg != OCPW_MODE_OFF;
    assign irq_event[`OCPW_IRQ_FAULT]   = fault_now && !fault_latched_reg;

    // Read clears; a same-cycle event survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 2'h0;
        end else if (rd_en && paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_IRQ_STATUS) begin
            // Clear only the bits that the read returned
            irq_status_reg <= (irq_status_reg & ~prdata[`OCPW_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= 2'h0;
        end else if (wr_en && paddr[`OCPW_ADDR_W-1:0] == `OCPW_OFF_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`OCPW_IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq                <= 1'b0;
            compare_output_pin <= 1'b0;
        end else begin
            irq                <= |(irq_status_reg & irq_mask_reg);
            compare_output_pin <= pin_reg;
        end
    end

endmodule

// *** ocpw_top_assertions.sv ***
// Checker: bus answer, control read-back and pin behaviour.
// Assumes binding to ocpw_top; sees only its ports.
`timescale 1ns/10ps
`include "ocpw_consts.svh"
module ocpw_top_assertions #(
    parameter int TIMER_W = 32
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [31:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [TIMER_W-1:0] first_timebase,
    input wire logic [TIMER_W-1:0] second_timebase,
    input wire logic               idle_mode,
    input wire logic               fault_n,
    input wire logic               compare_output_pin,
    input wire logic               irq
);
    // ****************************
    // Shadow of control and match
    // ****************************
    logic [31:0] ctl_reg;
    logic [31:0] pri_reg;
    logic [2:0]  age_reg;
    logic [31:0] cnt;
    logic        wr;
    logic        hit;
    logic        on;
    logic        rdc;
    assign wr  = psel && penable && pready && pwrite;
    assign rdc = pready && !pwrite && paddr[7:0] == `OCPW_OFF_CONTROL;
    assign on  = ctl_reg[15] && age_reg > 3'h3;
    assign cnt = ctl_reg[3] ? 32'(second_timebase) : 32'(first_timebase);
    assign hit = ctl_reg[5] ? cnt == pri_reg : cnt[15:0] == pri_reg[15:0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= 32'h00000000;
            pri_reg <= 32'h00000000;
            age_reg <= 3'h0;
        end else begin
            if (wr && paddr[7:0] == `OCPW_OFF_PRIMARY) begin
                pri_reg <= pwdata;
            end
            if (wr && paddr[7:0] == `OCPW_OFF_CONTROL) begin
                ctl_reg <= pwdata & `OCPW_CTRL_WMASK;
                age_reg <= 3'h0;
            end else if (age_reg != 3'h7) begin
                age_reg <= age_reg + 3'h1;
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no answer in access phase");
    property p_pulse; pready |-> psel && penable ##1 !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready outside one access cycle");
    property p_err; pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr[7:0] > 8'h10); endproperty
    a_err: assert property (p_err) else $error("pslverr wrong for address");
    property p_unimpl; rdc |-> (prdata & 32'hFFFF5FC0) == 32'h00000000; endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
    property p_flag; rdc && prdata[2:0] != 3'h7 |-> !prdata[4]; endproperty
    a_flag: assert property (p_flag) else $error("fault flag outside mode 7");
    property p_quiet; age_reg > 3'h2 && !(ctl_reg[15] && ctl_reg[2:0] != 3'h0) |-> !compare_output_pin;
    endproperty
    a_quiet: assert property (p_quiet) else $error("pin active while off");
    property p_tog; on && ctl_reg[2:0] == 3'h3 && $changed(compare_output_pin) |-> $past(hit, 2);
    endproperty
    a_tog: assert property (p_tog) else $error("toggle without compare");
    property p_hi; on && ctl_reg[2:0] == 3'h1 |-> !$fell(compare_output_pin); endproperty
    a_hi: assert property (p_hi) else $error("pin fell in set mode");
    property p_lo; on && ctl_reg[2:0] == 3'h2 |-> !$rose(compare_output_pin); endproperty
    a_lo: assert property (p_lo) else $error("pin rose in clear mode");
    property p_set; on && ctl_reg[2:0] == 3'h1 && !ctl_reg[13] && hit |-> ##2 compare_output_pin;
    endproperty
    a_set: assert property (p_set) else $error("compare did not set pin");
    c_err: cover property (pslverr);
    c_tog: cover property (on && ctl_reg[2:0] == 3'h3 && $changed(compare_output_pin));
    c_irq: cover property (irq);
endmodule
bind ocpw_top ocpw_top_assertions #(.TIMER_W(TIMER_W)) u_chk (.*);

// *** ocpw_load.sv ***
// Far-side model: fault source beside the pin's load.
// Assumes bench requests arrive by non-blocking assignment.
`timescale 1ns/10ps
module ocpw_load (
    input  wire logic pclk,
    input  wire logic fault_req,
    output logic      fault_n
);
    initial fault_n = 1'b1;
    always @(posedge pclk) fault_n <= !fault_req;
endmodule

// *** tb.sv ***
// Bench: register access, every compare mode, idle stop and fault.
// Assumes the design files and the load model are compiled first.
`timescale 1ns/10ps
`include "ocpw_consts.svh"
module tb;
    // ********************
    // Stimulus and checks
    // ********************
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        idle_mode = 1'b0, fault_req = 1'b0, fault_n, pin, irq, pready, pslverr, er;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [5:0]  cnt = 6'h00, p;
    int          errors = 0, checks = 0, seed = 32'h33fc;
    always #10 pclk = ~pclk;
    always @(posedge pclk) cnt <= cnt + 6'h01;
    ocpw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_timebase({16'hA5C3, 10'h000, cnt}),
        .second_timebase({16'hA5C3, 10'h000, cnt + 6'h11}), .idle_mode(idle_mode),
        .fault_n(fault_n), .compare_output_pin(pin), .irq(irq));
    ocpw_load u_load (.pclk(pclk), .fault_req(fault_req), .fault_n(fault_n));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        errors += int'(n >= 50);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic at(input logic ts, input logic [5:0] v);
        int n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((ts ? cnt + 6'h11 : cnt) !== v && n < 200);
        errors += int'(n >= 200);
    endtask
    function automatic logic exp_pin(input logic [2:0] m, input int ph);
        case (m)
            3'h1: return ph > 0;
            3'h2: return ph == 0;
            3'h3: return ph == 1 || ph == 2;
            3'h4: return ph == 1;
            3'h5, 3'h6, 3'h7: return ph == 1 || ph == 3;
            default: return 1'b0;
        endcase
    endfunction
    task automatic run(input logic [2:0] m, input logic [4:0] r, input logic flt);
        logic ev;
        p = 6'h1A + 6'($unsigned($random(seed)) % 16);
        ev = !(r[1] && r[2]) && !r[3] && m != 3'h0;
        at(r[0], 6'h00);
        apb(1'b1, `OCPW_OFF_CONTROL, 32'h0);
        apb(1'b0, `OCPW_OFF_IRQ_STATUS, 32'h0);
        apb(1'b1, `OCPW_OFF_IRQ_MASK, {30'h0, 1'b1, r[4]});
        apb(1'b1, `OCPW_OFF_PRIMARY, {r[2] ? 16'h5A3C : 16'hA5C3, 10'h000, p});
        apb(1'b1, `OCPW_OFF_SECONDARY, {16'hA5C3, 10'h000, p + 6'h10});
        apb(1'b1, `OCPW_OFF_CONTROL, {16'h0, 2'h2, r[3], 7'h00, r[1], 1'b0, r[0], m});
        repeat (2) @(posedge pclk);
        chk("initial pin", {31'h0, exp_pin(m, 0)}, {31'h0, pin});
        idle_mode <= 1'b1;
        for (int ph = 1; ph < 5 && !flt; ph++) begin
            at(r[0], ph % 2 ? p + 6'h04 : p + 6'h14);
            chk("pin", {31'h0, exp_pin(m, ev ? ph : 0)}, {31'h0, pin});
            if (ph == 1)
                chk("irq", {31'h0, ev && r[4]}, {31'h0, irq});
        end
        if (flt) begin
            at(1'b0, p + 6'h04);
            fault_req <= 1'b1;
            at(1'b0, p + 6'h0C);
            chk("fault pin", 32'h0, {31'h0, pin});
            chk("fault irq", 32'h1, {31'h0, irq});
            apb(1'b0, `OCPW_OFF_CONTROL, 32'h0);
            chk("fault flag", 32'h1, {31'h0, rd[4]});
            fault_req <= 1'b0;
            at(1'b0, p + 6'h04);
            chk("held pin", 32'h0, {31'h0, pin});
            apb(1'b1, `OCPW_OFF_CONTROL, 32'h0);
            apb(1'b1, `OCPW_OFF_CONTROL, 32'h8017);
            apb(1'b0, `OCPW_OFF_CONTROL, 32'h0);
            chk("flag cleared", 32'h8007, rd);
        end
        idle_mode <= 1'b0;
        apb(1'b0, `OCPW_OFF_IRQ_STATUS, 32'h0);
        chk("status", {30'h0, flt, ev}, rd);
        @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test mode %0d done", m);
    endtask
    initial begin
        logic [31:0] r;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OCPW_OFF_CONTROL, 32'h0);
        chk("control reset", 32'h0, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, `OCPW_OFF_CONTROL, 32'hFFFFFFFF);
        apb(1'b0, `OCPW_OFF_CONTROL, 32'h0);
        chk("control bits", 32'h0000A02F, rd);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            run(3'(i % 8), {r[4], r[3] && i > 7, r[2:0]}, 1'b0);
        end
        run(3'h7, 5'h00, 1'b1);
        tally_and_finish;
    end
    initial begin
        #600000;
        errors++;
        tally_and_finish;
    end
endmodule
